// *** rtl/sfcmd_map.vh ***
`ifndef SFCMD_MAP_VH
`define SFCMD_MAP_VH

// one-hot states of the command front end
`define SFCMD_ST_CMD    6'h01
`define SFCMD_ST_DEC    6'h02
`define SFCMD_ST_ADDR   6'h04
`define SFCMD_ST_DUMMY  6'h08
`define SFCMD_ST_DATA   6'h10
`define SFCMD_ST_HOLD   6'h20

// memory read opcodes, three-byte and four-byte address forms
`define SFCMD_OP_READ    8'h03
`define SFCMD_OP_READ4   8'h13
`define SFCMD_OP_FRD     8'h0b
`define SFCMD_OP_FRD4    8'h0c
`define SFCMD_OP_DOFR    8'h3b
`define SFCMD_OP_DOFR4   8'h3c
`define SFCMD_OP_DIOFR   8'hbb
`define SFCMD_OP_DIOFR4  8'hbc
`define SFCMD_OP_QOFR    8'h6b
`define SFCMD_OP_QOFR4   8'h6c
`define SFCMD_OP_QIOFR   8'heb
`define SFCMD_OP_QIOFR4  8'hec
`define SFCMD_OP_QWORD   8'he7
`define SFCMD_OP_DFR     8'h0d
`define SFCMD_OP_DFR4    8'h0e
`define SFCMD_OP_DDOFR   8'h3d
`define SFCMD_OP_DDIOFR  8'hbd
`define SFCMD_OP_DQOFR   8'h6d
`define SFCMD_OP_DQIOFR  8'hed

// latch and register opcodes
`define SFCMD_OP_WREN    8'h06
`define SFCMD_OP_WRDI    8'h04
`define SFCMD_OP_CLRFLAG 8'h50
`define SFCMD_OP_RDSR    8'h05
`define SFCMD_OP_RDFLAG  8'h70
`define SFCMD_OP_RDNVCR  8'hb5
`define SFCMD_OP_RDVCR   8'h85
`define SFCMD_OP_RDEVCR  8'h65
`define SFCMD_OP_RDEAR   8'hc8

// command kinds
`define SFCMD_K_NONE  3'h0
`define SFCMD_K_MEM   3'h1
`define SFCMD_K_REG   3'h2
`define SFCMD_K_WREN  3'h3
`define SFCMD_K_WRDI  3'h4
`define SFCMD_K_CLR   3'h5

// register select for register reads
`define SFCMD_R_SR    3'h0
`define SFCMD_R_FLAG  3'h1
`define SFCMD_R_NVCR  3'h2
`define SFCMD_R_VCR   3'h3
`define SFCMD_R_EVCR  3'h4
`define SFCMD_R_EAR   3'h5

// widths and counts
`define SFCMD_CMD_BITS   6'h08
`define SFCMD_ADDR3_BITS 6'h18
`define SFCMD_ADDR4_BITS 6'h20
`define SFCMD_BYTE_BITS  4'h8
`define SFCMD_WORD_DUMMY 5'h04
`define SFCMD_NVCR_LAST  2'h2

`endif

// *** rtl/sfcmd_sync.v ***
// two-flop synchroniser per pin plus a third stage for edge finding;
// the second and third stages feed logic, the first stays private
module sfcmd_sync #(
  parameter W = 6
) (
  input  wire         ref_clk,
  input  wire         rst,
  input  wire [W-1:0] async_in,
  input  wire [W-1:0] rst_val,
  output wire [W-1:0] sync_out,
  output wire [W-1:0] rise,
  output wire [W-1:0] fall
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_ff;
      reg sync_ff;
      reg last_ff;
      // reset to idle level chosen per bit by a constant at the instance
      always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          meta_ff <= 1'b0;
          sync_ff <= 1'b0;
          last_ff <= 1'b0;
        end else begin
          meta_ff <= async_in[i] ^ rst_val[i];
          sync_ff <= meta_ff;
          last_ff <= sync_ff;
        end
      end
      assign sync_out[i] = sync_ff ^ rst_val[i];
      assign rise[i]     = (sync_ff & ~last_ff) ^ (rst_val[i] & (sync_ff ^ last_ff));
      assign fall[i]     = (~sync_ff & last_ff) ^ (rst_val[i] & (sync_ff ^ last_ff));
    end
  endgenerate
endmodule

// *** rtl/sfcmd_top.v ***
// What this block does
// - plain read 03h/13h; address ends at 7+N ext, 3+N/2 dual, 1+N/4 quad
// - fast read 0Bh/0Ch uses the same command and address cycle counts
// - dual-output fast read 3Bh/3Ch: ext and dual only, ext address one line
// - dual i/o fast read BBh/BCh sends address on two lines in ext and dual
// - quad-output fast read 6Bh/6Ch: ext and quad; ext address one line
// - quad i/o fast read EBh/ECh: address and data on four lines
// - quad i/o word read E7h: address four bits per clock
// - double-rate fast read 0Dh/0Eh samples address on both clock edges
// - double-rate dual-output read 3Dh: ext and dual protocols only
// - double-rate dual i/o read BDh: address two lines per edge
// - double-rate quad-output 6Dh and quad i/o EDh address phases
// - select not raised right after latch opcode: nothing executes, latch stays
// - opcode 06h sets the write enable latch
// - write disable clears latch unless protection error; clear-flag clears both
// - register reads: ext in line 0 out line 1; dual 1:0; quad 3:0
// - raising select ends a register read and releases outputs at once
// - status 05h and flag 70h readable continuously, any time
// - nonvolatile config B5h: 16 bits low byte first, then zeros; reserved ones
// - 85h, 65h, C8h reads repeat the same byte while clocked
// - address bits latched on rising edge, on both edges in double rate; address advances per byte, wraps
// - word read: A0 forced 0, four dummies; ignored in dual and double rate
// - double-rate opcodes always double rate; others only when enabled
`include "sfcmd_map.vh"
module sfcmd_top #(
  parameter ADDR_W   = 28,
  parameter DUMMY_W  = 5,
  parameter NVCR_RSV = 16'h0000
) (
  input  wire               ref_clk,
  input  wire               rst,
  input  wire               sclk_pin,
  input  wire               sel_n_pin,
  input  wire [3:0]         dq_in,
  output reg  [3:0]         dq_out_ff,
  output reg  [3:0]         dq_oe_ff,
  input  wire               proto_dual,
  input  wire               proto_quad,
  input  wire               dtr_en,
  input  wire               addr4_en,
  input  wire [DUMMY_W-1:0] dummy_cfg,
  input  wire               prot_err,
  input  wire [7:0]         status_reg,
  input  wire [7:0]         flag_reg,
  input  wire [15:0]        nvcr_reg,
  input  wire [7:0]         vcr_reg,
  input  wire [7:0]         evcr_reg,
  input  wire [7:0]         ear_reg,
  input  wire [7:0]         mem_rdata,
  output reg  [ADDR_W-1:0]  mem_addr_ff,
  output reg                mem_rd_ff,
  output reg                wel_ff,
  output reg                flag_clr_ff
);

  // pins cross into ref_clk; select idles high so its stage resets high
  wire [5:0] pin_sync;
  wire [5:0] pin_rise;
  wire [5:0] pin_fall;
  sfcmd_sync #(.W(6)) u_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in ({sel_n_pin, sclk_pin, dq_in}),
    .rst_val  (6'h20),
    .sync_out (pin_sync),
    .rise     (pin_rise),
    .fall     (pin_fall)
  );
  wire       sel_n   = pin_sync[5];
  wire       sel_end = pin_rise[5];
  wire       sel_beg = pin_fall[5];
  wire       sck_r   = pin_rise[4] & ~sel_n;
  wire       sck_f   = pin_fall[4] & ~sel_n;
  wire [3:0] dq_s    = pin_sync[3:0];

  reg [5:0]         st_ff;
  reg               dtr_ff;
  reg [2:0]         lw_ff;
  reg [5:0]         cnt_ff;
  reg [7:0]         cmd_ff;
  reg [31:0]        addr_sh_ff;
  reg [5:0]         abits_ff;
  reg [2:0]         dw_ff;
  reg [2:0]         kind_ff;
  reg [2:0]         rsel_ff;
  reg               word_ff;
  reg [DUMMY_W-1:0] dummy_ff;
  reg [7:0]         osh_ff;
  reg [3:0]         obits_ff;
  reg [1:0]         ridx_ff;
  reg               pend_ff;

  // in double rate both edges carry bits, otherwise bits come in on the rising one and go out on the falling one
  wire cap_edge = sck_r | (dtr_ff & sck_f);
  wire out_edge = sck_f | (dtr_ff & sck_r);
  wire [2:0] plw = proto_quad ? 3'h4 : (proto_dual ? 3'h2 : 3'h1);

  // incoming bits for this edge, packed at the low end
  reg [3:0] in_bits;
  always @* begin
    case (lw_ff)
      3'h4:    in_bits = dq_s;
      3'h2:    in_bits = {2'h0, dq_s[1:0]};
      default: in_bits = {3'h0, dq_s[0]};
    endcase
  end

  // opcode decode: kind, line widths, rate, address size, validity
  reg [2:0] d_kind;
  reg [2:0] d_alw;
  reg [2:0] d_dw;
  reg       d_dtr;
  reg       d_a4;
  reg       d_dum;
  reg       d_word;
  reg [2:0] d_rsel;
  always @* begin
    d_kind = `SFCMD_K_MEM;
    d_alw  = plw;
    d_dw   = plw;
    d_dtr  = dtr_ff;
    d_a4   = addr4_en;
    d_dum  = 1'b1;
    d_word = 1'b0;
    d_rsel = `SFCMD_R_SR;
    case (cmd_ff)
      `SFCMD_OP_READ, `SFCMD_OP_READ4: begin
        d_dum = 1'b0;
        d_a4  = addr4_en | (cmd_ff == `SFCMD_OP_READ4);
      end
      `SFCMD_OP_FRD, `SFCMD_OP_FRD4:
        d_a4 = addr4_en | (cmd_ff == `SFCMD_OP_FRD4);
      `SFCMD_OP_DOFR, `SFCMD_OP_DOFR4: begin
        d_dw   = 3'h2;
        d_a4   = addr4_en | (cmd_ff == `SFCMD_OP_DOFR4);
        d_kind = proto_quad ? `SFCMD_K_NONE : `SFCMD_K_MEM;
      end
      `SFCMD_OP_DIOFR, `SFCMD_OP_DIOFR4: begin
        d_alw  = 3'h2;
        d_dw   = 3'h2;
        d_a4   = addr4_en | (cmd_ff == `SFCMD_OP_DIOFR4);
        d_kind = proto_quad ? `SFCMD_K_NONE : `SFCMD_K_MEM;
      end
      `SFCMD_OP_QOFR, `SFCMD_OP_QOFR4: begin
        d_dw   = 3'h4;
        d_a4   = addr4_en | (cmd_ff == `SFCMD_OP_QOFR4);
        d_kind = proto_dual ? `SFCMD_K_NONE : `SFCMD_K_MEM;
      end
      `SFCMD_OP_QIOFR, `SFCMD_OP_QIOFR4: begin
        d_alw  = 3'h4;
        d_dw   = 3'h4;
        d_a4   = addr4_en | (cmd_ff == `SFCMD_OP_QIOFR4);
        d_kind = proto_dual ? `SFCMD_K_NONE : `SFCMD_K_MEM;
      end
      `SFCMD_OP_QWORD: begin
        d_alw  = 3'h4;
        d_dw   = 3'h4;
        d_word = 1'b1;
        d_kind = (proto_dual | dtr_ff) ? `SFCMD_K_NONE : `SFCMD_K_MEM;
      end
      `SFCMD_OP_DFR, `SFCMD_OP_DFR4: begin
        d_dtr = 1'b1;
        d_a4  = addr4_en | (cmd_ff == `SFCMD_OP_DFR4);
      end
      `SFCMD_OP_DDOFR: begin
        d_dtr  = 1'b1;
        d_dw   = 3'h2;
        d_kind = proto_quad ? `SFCMD_K_NONE : `SFCMD_K_MEM;
      end
      `SFCMD_OP_DDIOFR: begin
        d_dtr  = 1'b1;
        d_alw  = 3'h2;
        d_dw   = 3'h2;
        d_kind = proto_quad ? `SFCMD_K_NONE : `SFCMD_K_MEM;
      end
      `SFCMD_OP_DQOFR, `SFCMD_OP_DQIOFR: begin
        d_dtr  = 1'b1;
        d_alw  = (cmd_ff == `SFCMD_OP_DQIOFR) ? 3'h4 : plw;
        d_dw   = 3'h4;
        d_kind = proto_dual ? `SFCMD_K_NONE : `SFCMD_K_MEM;
      end
      `SFCMD_OP_WREN:    d_kind = `SFCMD_K_WREN;
      `SFCMD_OP_WRDI:    d_kind = `SFCMD_K_WRDI;
      `SFCMD_OP_CLRFLAG: d_kind = `SFCMD_K_CLR;
      `SFCMD_OP_RDSR:    d_kind = `SFCMD_K_REG;
      `SFCMD_OP_RDFLAG: begin
        d_kind = `SFCMD_K_REG;
        d_rsel = `SFCMD_R_FLAG;
      end
      `SFCMD_OP_RDNVCR: begin
        d_kind = `SFCMD_K_REG;
        d_rsel = `SFCMD_R_NVCR;
      end
      `SFCMD_OP_RDVCR: begin
        d_kind = `SFCMD_K_REG;
        d_rsel = `SFCMD_R_VCR;
      end
      `SFCMD_OP_RDEVCR: begin
        d_kind = `SFCMD_K_REG;
        d_rsel = `SFCMD_R_EVCR;
      end
      `SFCMD_OP_RDEAR: begin
        d_kind = `SFCMD_K_REG;
        d_rsel = `SFCMD_R_EAR;
      end
      default: d_kind = `SFCMD_K_NONE;
    endcase
  end

  // byte to send: live register values so status polling sees changes
  reg [7:0] reg_byte;
  always @* begin
    case (rsel_ff)
      `SFCMD_R_FLAG: reg_byte = flag_reg;
      `SFCMD_R_NVCR: begin
        if (ridx_ff == 2'h0)
          reg_byte = nvcr_reg[7:0] | NVCR_RSV[7:0];
        else if (ridx_ff == 2'h1)
          reg_byte = nvcr_reg[15:8] | NVCR_RSV[15:8];
        else
          reg_byte = 8'h00;
      end
      `SFCMD_R_VCR:  reg_byte = vcr_reg;
      `SFCMD_R_EVCR: reg_byte = evcr_reg;
      `SFCMD_R_EAR:  reg_byte = ear_reg;
      default:       reg_byte = status_reg;
    endcase
  end
  wire [7:0] src_byte = (kind_ff == `SFCMD_K_MEM) ? mem_rdata : reg_byte;
  wire [7:0] cur_byte = (obits_ff == 4'h0) ? src_byte : osh_ff;

  // top bits of the byte go out; one-line data leaves on line one
  reg [3:0] drv_val;
  reg [3:0] drv_oe;
  always @* begin
    case (dw_ff)
      3'h4: begin
        drv_val = cur_byte[7:4];
        drv_oe  = 4'hf;
      end
      3'h2: begin
        drv_val = {2'h0, cur_byte[7:6]};
        drv_oe  = 4'h3;
      end
      default: begin
        drv_val = {2'h0, cur_byte[7], 1'b0};
        drv_oe  = 4'h2;
      end
    endcase
  end

  wire [5:0] nxt_cnt  = cnt_ff + {3'h0, lw_ff};
  wire [3:0] dw_bits  = {1'b0, dw_ff};
  wire       dum_last = (dummy_ff <= {{(DUMMY_W-1){1'b0}}, 1'b1});

  // command sequencer; select high always returns it to idle
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_ff       <= `SFCMD_ST_CMD;
      dtr_ff      <= 1'b0;
      lw_ff       <= 3'h1;
      cnt_ff      <= 6'h00;
      cmd_ff      <= 8'h00;
      addr_sh_ff  <= 32'h0000_0000;
      abits_ff    <= `SFCMD_ADDR3_BITS;
      dw_ff       <= 3'h1;
      kind_ff     <= `SFCMD_K_NONE;
      rsel_ff     <= `SFCMD_R_SR;
      word_ff     <= 1'b0;
      dummy_ff    <= {DUMMY_W{1'b0}};
      osh_ff      <= 8'h00;
      obits_ff    <= 4'h0;
      ridx_ff     <= 2'h0;
      pend_ff     <= 1'b0;
      dq_out_ff   <= 4'h0;
      dq_oe_ff    <= 4'h0;
      mem_addr_ff <= {ADDR_W{1'b0}};
      mem_rd_ff   <= 1'b0;
      wel_ff      <= 1'b0;
      flag_clr_ff <= 1'b0;
    end else begin
      flag_clr_ff <= 1'b0;
      if (sel_end) begin
        // frame over: outputs released, latch commands run only if clean
        st_ff     <= `SFCMD_ST_CMD;
        dq_oe_ff  <= 4'h0;
        mem_rd_ff <= 1'b0;
        pend_ff   <= 1'b0;
        if (pend_ff) begin
          if (kind_ff == `SFCMD_K_WREN)
            wel_ff <= 1'b1;
          else if (kind_ff == `SFCMD_K_WRDI && !prot_err)
            wel_ff <= 1'b0;
          else if (kind_ff == `SFCMD_K_CLR) begin
            wel_ff      <= 1'b0;
            flag_clr_ff <= 1'b1;
          end
        end
      end else if (sel_beg) begin
        // new frame: opcode width from protocol, rate from configuration
        st_ff    <= `SFCMD_ST_CMD;
        cnt_ff   <= 6'h00;
        lw_ff    <= plw;
        dtr_ff   <= dtr_en;
        kind_ff  <= `SFCMD_K_NONE;
        obits_ff <= 4'h0;
        ridx_ff  <= 2'h0;
      end else begin
        case (st_ff)
          `SFCMD_ST_CMD: begin
            if (cap_edge) begin
              cmd_ff <= (cmd_ff << lw_ff) | {4'h0, in_bits};
              cnt_ff <= nxt_cnt;
              if (nxt_cnt == `SFCMD_CMD_BITS)
                st_ff <= `SFCMD_ST_DEC;
            end
          end
          `SFCMD_ST_DEC: begin
            kind_ff    <= d_kind;
            rsel_ff    <= d_rsel;
            dw_ff      <= d_dw;
            word_ff    <= d_word;
            lw_ff      <= d_alw;
            dtr_ff     <= d_dtr;
            cnt_ff     <= 6'h00;
            addr_sh_ff <= 32'h0000_0000;
            abits_ff   <= d_a4 ? `SFCMD_ADDR4_BITS : `SFCMD_ADDR3_BITS;
            dummy_ff   <= d_word ? `SFCMD_WORD_DUMMY : (d_dum ? dummy_cfg : {DUMMY_W{1'b0}});
            if (d_kind == `SFCMD_K_MEM)
              st_ff <= `SFCMD_ST_ADDR;
            else if (d_kind == `SFCMD_K_REG) begin
              st_ff <= `SFCMD_ST_DATA;
              dw_ff <= plw;
            end else begin
              st_ff   <= `SFCMD_ST_HOLD;
              pend_ff <= (d_kind != `SFCMD_K_NONE);
            end
          end
          `SFCMD_ST_ADDR: begin
            // the fall closing the last opcode clock is no address beat in double rate
            if (sck_r | (cap_edge & (cnt_ff != 6'h00))) begin
              addr_sh_ff <= (addr_sh_ff << lw_ff) | {28'h0, in_bits};
              cnt_ff     <= nxt_cnt;
              if (nxt_cnt == abits_ff) begin
                mem_addr_ff <= ((addr_sh_ff[ADDR_W-1:0] << lw_ff) |
                                {{(ADDR_W-4){1'b0}}, in_bits}) &
                               ~{{(ADDR_W-1){1'b0}}, word_ff};
                mem_rd_ff   <= 1'b1;
                if (dummy_ff == {DUMMY_W{1'b0}})
                  st_ff <= `SFCMD_ST_DATA;
                else
                  st_ff <= `SFCMD_ST_DUMMY;
              end
            end
          end
          `SFCMD_ST_DUMMY: begin
            // dummy clocks counted per full clock, on the rising edge
            if (sck_r) begin
              dummy_ff <= dummy_ff - {{(DUMMY_W-1){1'b0}}, 1'b1};
              if (dum_last)
                st_ff <= `SFCMD_ST_DATA;
            end
          end
          `SFCMD_ST_DATA: begin
            if (out_edge) begin
              dq_out_ff <= drv_val;
              dq_oe_ff  <= drv_oe;
              osh_ff    <= cur_byte << dw_ff;
              if (obits_ff == 4'h0) begin
                obits_ff <= `SFCMD_BYTE_BITS - dw_bits;
                // next byte fetched while this one shifts; wraps at the top
                if (kind_ff == `SFCMD_K_MEM)
                  mem_addr_ff <= mem_addr_ff + {{(ADDR_W-1){1'b0}}, 1'b1};
                else if (rsel_ff == `SFCMD_R_NVCR && ridx_ff != `SFCMD_NVCR_LAST)
                  ridx_ff <= ridx_ff + 2'h1;
              end else begin
                obits_ff <= obits_ff - dw_bits;
              end
            end
          end
          default: begin
            // any clock after a latch opcode cancels it
            if (sck_r)
              pend_ff <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

// *** tb/sfcmd_properties.sv ***
// watches the top ports only; one clock domain, the link pins are sampled
module sfcmd_chk #(
  parameter ADDR_W  = 28,
  parameter DUMMY_W = 5
) (
  input wire              ref_clk,
  input wire              rst,
  input wire              sclk_pin,
  input wire              sel_n_pin,
  input wire              proto_dual,
  input wire              proto_quad,
  input wire              prot_err,
  input wire [3:0]        dq_oe_ff,
  input wire [ADDR_W-1:0] mem_addr_ff,
  input wire              mem_rd_ff,
  input wire              wel_ff,
  input wire              flag_clr_ff
);
  logic       sclk_q_ff;
  logic [7:0] rise_cnt_ff;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // raw serial clock rises in the frame; saturates so long reads cannot wrap it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclk_q_ff   <= 1'b0;
      rise_cnt_ff <= 8'h00;
    end else begin
      sclk_q_ff <= sclk_pin;
      if (sel_n_pin)
        rise_cnt_ff <= 8'h00;
      else if (sclk_pin && !sclk_q_ff && rise_cnt_ff != 8'hff)
        rise_cnt_ff <= rise_cnt_ff + 8'h01;
    end
  end

  AST_OE_RELEASE: assert property ($rose(sel_n_pin) |-> ##[1:6] (dq_oe_ff == 4'h0))
    else $error("lines still driven after select rose");
  AST_IDLE_RD: assert property (sel_n_pin [*6] |-> !mem_rd_ff)
    else $error("memory read active outside a frame");
  AST_WEL_AT_SEL: assert property ($changed(wel_ff) |-> sel_n_pin && $past(sel_n_pin, 2))
    else $error("latch changed while selected");
  AST_WEL_PROT: assert property ($fell(wel_ff) && prot_err |->
      (flag_clr_ff || $past(flag_clr_ff) || $past(flag_clr_ff, 2)) or ##[1:2] flag_clr_ff)
    else $error("latch cleared under protection error without clear-flag");
  AST_CLR_PULSE: assert property (flag_clr_ff |-> sel_n_pin ##1 !flag_clr_ff)
    else $error("clear-flag pulse malformed");
  AST_DUAL_LINES: assert property (proto_dual && !proto_quad |-> dq_oe_ff[3:2] == 2'h0)
    else $error("upper lines driven in dual protocol");
  AST_EARLY_DRIVE: assert property (!proto_dual && !proto_quad && !sel_n_pin
      && rise_cnt_ff < 8'd8 |-> dq_oe_ff == 4'h0)
    else $error("output driven before opcode complete");
  AST_ADDR_STEP: assert property (mem_rd_ff && $past(mem_rd_ff) && $changed(mem_addr_ff)
      |-> mem_addr_ff == $past(mem_addr_ff) + 1'b1)
    else $error("address did not advance by one");
  AST_EXT_START: assert property (!proto_dual && !proto_quad && $rose(mem_rd_ff)
      |-> rise_cnt_ff >= 8'd14)
    else $error("memory read began before address complete");
endmodule

bind sfcmd_top sfcmd_chk #(.ADDR_W(ADDR_W), .DUMMY_W(DUMMY_W)) u_chk (
  .ref_clk(ref_clk), .rst(rst), .sclk_pin(sclk_pin), .sel_n_pin(sel_n_pin),
  .proto_dual(proto_dual), .proto_quad(proto_quad), .prot_err(prot_err),
  .dq_oe_ff(dq_oe_ff), .mem_addr_ff(mem_addr_ff), .mem_rd_ff(mem_rd_ff),
  .wel_ff(wel_ff), .flag_clr_ff(flag_clr_ff)
);

// *** tb/sfcmd_host.sv ***
// host controller model; serial clock stands low outside frames
module sfcmd_host (
  input  wire logic [3:0] dq_line,
  input  wire logic       ref_clk,
  output logic            sclk_pin,
  output logic            sel_n_pin,
  output logic [3:0]      host_dq
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    sclk_pin  = 1'b0;
    sel_n_pin = 1'b1;
    host_dq   = 4'h5;
  end

  // 16 cycles of 5 ns give half of the 160 ns link period
  task automatic half();
    repeat (16) @(negedge ref_clk);
  endtask

  task automatic start();
    @(negedge ref_clk);
    sel_n_pin = 1'b0;
    half();
  endtask

  // msb first, w bits per clock on the low lines
  task automatic put(input logic [31:0] v, input int nclk, input int w);
    logic [31:0] s;
    s = v << (32 - nclk * w);
    repeat (nclk) begin
      host_dq = 4'(s[31:28] >> (4 - w));
      s = s << w;
      half();
      sclk_pin = 1'b1;
      half();
      sclk_pin = 1'b0;
    end
  endtask

  // double rate on one line: a beat per edge, data moved between edges
  task automatic put_dtr(input logic [31:0] v, input int nbeat);
    logic [31:0] s;
    s = v << (32 - nbeat);
    repeat (nbeat) begin
      host_dq = {3'h0, s[31]};
      s = s << 1;
      repeat (8) @(negedge ref_clk);
      sclk_pin = ~sclk_pin;
      repeat (8) @(negedge ref_clk);
    end
  endtask

  // released lines toggle so a stale value never looks like data
  task automatic get(output logic [31:0] v, input int nclk, input int w);
    v = '0;
    repeat (nclk) begin
      host_dq = ~host_dq;
      half();
      v = (w == 1) ? {v[30:0], dq_line[1]} : (v << w) | 32'(dq_line & 4'((1 << w) - 1));
      sclk_pin = 1'b1;
      half();
      sclk_pin = 1'b0;
    end
  endtask

  // select rises half a clock after the last bit, then stays high a while
  task automatic stop();
    half();
    sel_n_pin = 1'b1;
    host_dq   = ~host_dq;
    repeat (8) @(negedge ref_clk);
  endtask
endmodule

// *** tb/sfcmd_top_tb.sv ***
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module sfcmd_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        sclk_pin, sel_n_pin, proto_dual, proto_quad, dtr_en, addr4_en, prot_err;
  logic [4:0]  dummy_cfg;
  logic [3:0]  host_dq, dq_line, dq_out_ff, dq_oe_ff;
  logic [7:0]  status_reg, flag_reg, vcr_reg, evcr_reg, ear_reg, mem_rdata, op;
  logic [15:0] nvcr_reg, val;
  logic [23:0] ex;
  logic [27:0] mem_addr_ff;
  logic        mem_rd_ff, wel_ff, flag_clr_ff;
  logic [31:0] v;
  int          num_errors = 0;
  int          check_count = 0;
  // opcode, register value, three expected bytes
  localparam logic [47:0] ROWS [6] = '{48'h05_00a5_a5a5a5, 48'h70_003c_3c3c3c,
    48'h85_00f1_f1f1f1, 48'h65_0017_171717, 48'hc8_0082_828282, 48'hb5_beef_efbe00};

  always #2.5 ref_clk = ~ref_clk;
  // wire level: the design wins where it drives, the host elsewhere
  assign dq_line = (dq_oe_ff & dq_out_ff) | (~dq_oe_ff & host_dq);

  function automatic logic [7:0] exp_byte(input logic [27:0] a);
    return a[7:0] ^ a[15:8];
  endfunction

  // array byte one cycle after the address, as the contract asks
  always @(posedge ref_clk) mem_rdata <= exp_byte(mem_addr_ff);

  sfcmd_host host (.dq_line(dq_line), .ref_clk(ref_clk), .sclk_pin(sclk_pin),
    .sel_n_pin(sel_n_pin), .host_dq(host_dq));

  sfcmd_top uut (.ref_clk(ref_clk), .rst(rst), .sclk_pin(sclk_pin), .sel_n_pin(sel_n_pin),
    .dq_in(dq_line), .dq_out_ff(dq_out_ff), .dq_oe_ff(dq_oe_ff), .proto_dual(proto_dual),
    .proto_quad(proto_quad), .dtr_en(dtr_en), .addr4_en(addr4_en), .dummy_cfg(dummy_cfg),
    .prot_err(prot_err), .status_reg(status_reg), .flag_reg(flag_reg), .nvcr_reg(nvcr_reg),
    .vcr_reg(vcr_reg), .evcr_reg(evcr_reg), .ear_reg(ear_reg), .mem_rdata(mem_rdata),
    .mem_addr_ff(mem_addr_ff), .mem_rd_ff(mem_rd_ff), .wel_ff(wel_ff),
    .flag_clr_ff(flag_clr_ff));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic wr_latch(input logic [7:0] c);
    host.start();
    host.put(c, 8, 1);
    host.stop();
  endtask

  // a read that the protocol does not define must leave the lines undriven
  task automatic refuse(input logic d, input logic q, input logic [7:0] c);
    int w;
    proto_dual = d;
    proto_quad = q;
    w = q ? 4 : (d ? 2 : 1);
    host.start();
    host.put(c, 8 / w, w);
    host.put(24'h000100, 24 / w, w);
    host.put(0, 8, w);
    host.get(v, 2, w);
    `CHK(dq_oe_ff, 4'h0)
    host.stop();
  endtask

  // cap at about two and a half times the eighty or so microseconds the sequence needs
  initial begin
    #200us;
    num_errors++;
    print_verdict();
  end

  initial begin
    {proto_dual, proto_quad, dtr_en, addr4_en, prot_err} = 5'h00;
    dummy_cfg = 5'd8;
    {status_reg, flag_reg, vcr_reg, evcr_reg, ear_reg, nvcr_reg} = '0;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk) rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    foreach (ROWS[i]) begin
      {op, val, ex} = ROWS[i];
      {status_reg, flag_reg, vcr_reg, evcr_reg, ear_reg} = {5{val[7:0]}};
      nvcr_reg = val;
      host.start();
      host.put(op, 8, 1);
      host.get(v, 24, 1);
      host.stop();
      `CHK(v[23:0], ex)
    end
    $display("register table done");
    wr_latch(8'h06);
    `CHK(wel_ff, 1'b1)
    wr_latch(8'h04);
    `CHK(wel_ff, 1'b0)
    wr_latch(8'h06);
    prot_err = 1'b1;
    wr_latch(8'h04);
    `CHK(wel_ff, 1'b1)
    wr_latch(8'h50);
    `CHK(wel_ff, 1'b0)
    prot_err = 1'b0;
    host.start();
    host.put(8'h06, 8, 1);
    host.put(1, 1, 1);
    host.stop();
    `CHK(wel_ff, 1'b0)
    $display("latch tests done");
    host.start();
    host.put(8'h03, 8, 1);
    host.put(24'h1234ff, 24, 1);
    `CHK(mem_addr_ff, 28'h01234ff)
    `CHK(mem_rd_ff, 1'b1)
    host.get(v, 16, 1);
    host.stop();
    `CHK(v[15:0], {exp_byte(28'h01234ff), exp_byte(28'h0123500)})
    host.start();
    host.put(8'h0b, 8, 1);
    host.put(24'h000a10, 24, 1);
    host.put(0, 8, 1);
    host.get(v, 8, 1);
    host.stop();
    `CHK(v[7:0], exp_byte(28'h0000a10))
    host.start();
    host.put(8'h13, 8, 1);
    host.put(32'h1abcdef0, 32, 1);
    `CHK(mem_addr_ff, 28'habcdef0)
    host.stop();
    host.start();
    host.put(8'h0d, 8, 1);
    host.put_dtr(24'h00abcd, 24);
    `CHK(mem_addr_ff, 28'h000abcd)
    host.stop();
    $display("memory read tests done");
    // status polled first, as a host should before its next command
    status_reg = 8'h69;
    proto_quad = 1'b1;
    host.start();
    host.put(8'h05, 2, 4);
    host.get(v, 4, 4);
    host.stop();
    `CHK(v[15:0], 16'h6969)
    host.start();
    host.put(8'he7, 2, 4);
    host.put(24'h000123, 6, 4);
    `CHK(mem_addr_ff, 28'h0000122)
    host.stop();
    flag_reg   = 8'hc3;
    proto_quad = 1'b0;
    proto_dual = 1'b1;
    host.start();
    host.put(8'h70, 4, 2);
    host.get(v, 8, 2);
    host.stop();
    `CHK(v[15:0], 16'hc3c3)
    refuse(1'b0, 1'b1, 8'h3b);
    refuse(1'b1, 1'b0, 8'he7);
    proto_dual = 1'b0;
    $display("protocol width tests done");
    host.start();
    host.put(8'h05, 8, 1);
    host.get(v, 3, 1);
    host.stop();
    `CHK(dq_oe_ff, 4'h0)
    wr_latch(8'h06);
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    `CHK(wel_ff, 1'b0)
    `CHK(dq_oe_ff, 4'h0)
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    $display("abort and reset tests done");
    print_verdict();
  end
endmodule
